// >>> design/serial_config_pkg.sv
// Shared constants for the serial configuration port
package serial_config_pkg;
	localparam int ADDR_W = 5;
	localparam int NUM_REGS = 32;
	localparam int MAX_BYTES = 8;
	localparam int DATA_W = 64;
	localparam int CMD_RW_BIT = 7;
	localparam int CMD_ADDR_LSB = 0;
	localparam logic [4:0] ADDR_CTRL1 = 5'h00;
	localparam logic [4:0] ADDR_CTRL2 = 5'h01;
	localparam logic [4:0] ADDR_PROFILE_FIRST = 5'h0E;
	localparam logic [4:0] ADDR_PROFILE_LAST = 5'h15;
	localparam int CTRL1_LSB_FIRST_BIT = 0;
	localparam int CTRL1_THREE_WIRE_BIT = 1;
	localparam logic [63:0] REG_RESET = 64'h0;
	localparam int HOST_CLK_DIV = 2;
	// Byte width of each register; 0x01 is four bytes
	function automatic logic [3:0] reg_bytes(input logic [4:0] a);
		logic [3:0] n;
		n = 4'h4;
		if (a == 5'h03 || a == 5'h04 || a == 5'h07 || a == 5'h08)
			n = 4'h4;
		else if (a == 5'h05 || a == 5'h06)
			n = 4'h2;
		else if (a == 5'h09 || a == 5'h0A)
			n = 4'h4;
		else if (a == 5'h0B || a == 5'h0C)
			n = 4'h8;
		else if (a == 5'h0D)
			n = 4'h4;
		else if (a >= ADDR_PROFILE_FIRST && a <= ADDR_PROFILE_LAST)
			n = 4'h8;
		else if (a == 5'h16)
			n = 4'h4;
		return n;
	endfunction : reg_bytes
endpackage : serial_config_pkg

// >>> design/serial_config_if.sv
// Wires joining the serial host and the configuration port
`timescale 1ns/10ps
interface serial_config_if;
	logic sclk;
	logic cs_n;
	logic port_abort;
	logic commit;
	logic [2:0] profile_sel;
	logic sdio_host_out;
	logic sdio_host_oe;
	logic sdio_dev_out;
	logic sdio_dev_oe;
	logic serial_data_out;
	logic serial_data_out_oe;
	logic sdio;
	logic sdo_line;
	assign sdio = sdio_dev_oe ? sdio_dev_out : (sdio_host_oe ? sdio_host_out : 1'b1);
	assign sdo_line = serial_data_out_oe ? serial_data_out : 1'b1;
	modport device (input sclk, input cs_n, input port_abort, input commit, input profile_sel, input sdio,
		output sdio_dev_out, output sdio_dev_oe, output serial_data_out, output serial_data_out_oe);
	modport host (output sclk, output cs_n, output port_abort, output commit, output profile_sel,
		output sdio_host_out, output sdio_host_oe, input sdio, input sdo_line);
endinterface : serial_config_if

// >>> design/serial_config_port.sv
// Device end: serial shifter, port buffer and active registers
//
// Behaviour
// - Command byte, then data phase
// - Command holds address and read/write
// - Data length equals register byte width
// - Write bits captured on rising clock
// - Host sends every byte of register
// - Abort ends transaction, next byte command
// - Abort keeps whole bytes, drops partial
// - After completion next eight edges command
// - Written data inactive until commit
// - Commit strobe copies buffer to active
// - Profile select change also commits
// - Reads return active register contents
// - Read bits driven on falling clock
// - Host sets profile before profile read
// - Profile writes ignore profile select
// - MSB-first or LSB-first ordering
// - Two-wire or three-wire data lines
// - All registers readable and writable
// - Bit7 read, bits 4..0 address
// - Chip select high tristates and suspends
// - LSB-first applies to command too
// - Commit rising edge, held long
`timescale 1ns/10ps
module serial_config_port #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk,
	input wire logic reset,
	serial_config_if.device link,
	output logic [63:0] active_data [32],
	output logic commit_done
);
	if (SYNC_STAGES != 2)
	begin : g_bad_sync
		$error("SYNC_STAGES must be 2");
	end

	typedef enum logic [0:0] {
		PH_CMD = 1'b0,
		PH_DATA = 1'b1
	} phase_t;

	// Byte slot in the register; LSB-first order fills it from the low byte
	function automatic logic [2:0] byte_slot(input logic lsb, input logic [4:0] a, input logic [3:0] left);
		logic [3:0] s;
		s = lsb ? serial_config_pkg::reg_bytes(a) - left : left - 4'h1;
		return s[2:0];
	endfunction : byte_slot

	// Link domain: shifter runs on sclk
	phase_t phase, next_phase;
	logic [7:0] shreg, next_shreg;
	logic [2:0] bitcnt, next_bitcnt;
	logic [3:0] bytecnt, next_bytecnt;
	logic rd, next_rd;
	logic [4:0] addr, next_addr;
	logic [63:0] pbuf [32];
	logic [63:0] next_pbuf [32];
	logic [7:0] rd_byte;
	logic lsb_first, three_wire;
	logic [7:0] in_byte;

	// Control bits come from active register 0x00
	assign lsb_first = active_data[serial_config_pkg::ADDR_CTRL1][serial_config_pkg::CTRL1_LSB_FIRST_BIT];
	assign three_wire = active_data[serial_config_pkg::ADDR_CTRL1][serial_config_pkg::CTRL1_THREE_WIRE_BIT];

	always_comb
	begin
		next_phase = phase;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_bytecnt = bytecnt;
		next_rd = rd;
		next_addr = addr;
		next_pbuf = pbuf;
		in_byte = lsb_first ? {link.sdio, shreg[7:1]} : {shreg[6:0], link.sdio};
		if (!link.cs_n)
		begin
			next_shreg = in_byte;
			next_bitcnt = bitcnt + 3'h1;
			if (bitcnt == 3'h7)
			begin
				if (phase == PH_CMD)
				begin
					next_rd = in_byte[serial_config_pkg::CMD_RW_BIT];
					next_addr = in_byte[4:0];
					next_bytecnt = serial_config_pkg::reg_bytes(in_byte[4:0]);
					next_phase = PH_DATA;
				end
				else
				begin
					// MSB-first sends the top byte first, LSB-first the bottom one
					if (!rd)
						next_pbuf[addr][{byte_slot(lsb_first, addr, bytecnt), 3'b000} +: 8] = in_byte;
					next_bytecnt = bytecnt - 4'h1;
					if (bytecnt == 4'h1)
						next_phase = PH_CMD;
				end
			end
		end
	end

	// Abort is asynchronous to sclk, so it acts as a reset of the sequencer
	always_ff @(posedge link.sclk or posedge reset or posedge link.port_abort)
	begin
		if (reset || link.port_abort)
		begin
			phase <= PH_CMD;
			shreg <= 8'h00;
			bitcnt <= 3'h0;
			bytecnt <= 4'h0;
			rd <= 1'b0;
			addr <= 5'h00;
		end
		else
		begin
			phase <= next_phase;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			bytecnt <= next_bytecnt;
			rd <= next_rd;
			addr <= next_addr;
		end
	end

	// Buffer survives abort; partial bytes never reach it
	always_ff @(posedge link.sclk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < 32; i++)
				pbuf[i] <= serial_config_pkg::REG_RESET;
		end
		else if (!link.port_abort)
			pbuf <= next_pbuf;
	end

	// Read byte selection; bytes are read from active registers
	always_comb
	begin
		rd_byte = active_data[addr][{byte_slot(lsb_first, addr, bytecnt), 3'b000} +: 8];
	end

	logic out_bit, next_out_bit;
	logic out_en, next_out_en;
	always_comb
	begin
		next_out_bit = out_bit;
		next_out_en = 1'b0;
		if (phase == PH_DATA && rd && !link.cs_n)
		begin
			next_out_en = 1'b1;
			next_out_bit = lsb_first ? rd_byte[bitcnt] : rd_byte[3'h7 - bitcnt];
		end
	end

	always_ff @(negedge link.sclk or posedge reset)
	begin
		if (reset)
		begin
			out_bit <= 1'b0;
			out_en <= 1'b0;
		end
		else
		begin
			out_bit <= next_out_bit;
			out_en <= next_out_en;
		end
	end

	assign link.sdio_dev_out = out_bit;
	assign link.sdio_dev_oe = out_en && !three_wire && !link.cs_n;
	assign link.serial_data_out = out_bit;
	assign link.serial_data_out_oe = out_en && three_wire && !link.cs_n;

	// System domain: commit strobe and profile change, two-stage synchronised
	logic [1:0] commit_sync, next_commit_sync;
	logic [2:0] prof_s1, prof_s2, prof_last;
	logic commit_prev, next_commit_prev;
	logic do_commit;
	logic [63:0] next_active [32];
	logic next_commit_done;

	assign next_commit_sync = {commit_sync[0], link.commit};
	assign next_commit_prev = commit_sync[1];

	always_comb
	begin
		do_commit = (commit_sync[1] && !commit_prev) || (prof_s2 != prof_last);
		next_active = active_data;
		next_commit_done = do_commit;
		if (do_commit)
			next_active = pbuf;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			commit_sync <= 2'h0;
			commit_prev <= 1'b0;
			prof_s1 <= 3'h0;
			prof_s2 <= 3'h0;
			prof_last <= 3'h0;
			commit_done <= 1'b0;
			for (int i = 0; i < 32; i++)
				active_data[i] <= serial_config_pkg::REG_RESET;
		end
		else
		begin
			commit_sync <= next_commit_sync;
			commit_prev <= next_commit_prev;
			prof_s1 <= link.profile_sel;
			prof_s2 <= prof_s1;
			prof_last <= prof_s2;
			commit_done <= next_commit_done;
			active_data <= next_active;
		end
	end
endmodule : serial_config_port

// >>> design/serial_config_host.sv
// Host end: issues one whole register transaction per request
`timescale 1ns/10ps
module serial_config_host (
	input wire logic clk,
	input wire logic reset,
	serial_config_if.host link,
	input wire logic req,
	input wire logic req_read,
	input wire logic [4:0] req_addr,
	input wire logic [63:0] req_wdata,
	input wire logic lsb_first,
	input wire logic three_wire,
	input wire logic commit_req,
	input wire logic abort_req,
	input wire logic [2:0] profile,
	output logic busy,
	output logic done,
	output logic [63:0] rdata
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_COMMIT = 2'b10
	} state_t;

	state_t state, next_state;
	logic [71:0] tx, next_tx;
	logic [6:0] bits_left, next_bits_left;
	logic sclk, next_sclk;
	logic cs_n, next_cs_n;
	logic rd, next_rd;
	logic [63:0] rx, next_rx;
	logic [1:0] cnt, next_cnt;
	logic commit, next_commit;
	logic abort, next_abort;
	logic [1:0] s1, s2;
	logic din;
	logic [3:0] nbytes;
	logic next_done;
	logic [3:0] nb, next_nb;
	logic lsb, next_lsb;
	logic drive, next_drive;
	logic [7:0] cmd;
	logic [5:0] rx_pos;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction : rev8

	function automatic logic [63:0] rev64(input logic [63:0] v);
		logic [63:0] r;
		for (int i = 0; i < 64; i++)
			r[i] = v[63 - i];
		return r;
	endfunction : rev64

	assign nbytes = serial_config_pkg::reg_bytes(req_addr);
	assign din = three_wire ? s2[1] : s2[0];
	assign cmd = {req_read, 2'b00, req_addr};
	// Read bits land by weight, so either order ends right-aligned
	assign rx_pos = lsb ? 6'(nb * 8 - 1 - bits_left) : bits_left[5:0];

	always_comb
	begin
		next_state = state;
		next_tx = tx;
		next_bits_left = bits_left;
		next_sclk = sclk;
		next_cs_n = cs_n;
		next_rd = rd;
		next_rx = rx;
		next_cnt = cnt;
		next_commit = commit;
		next_abort = abort_req;
		next_done = 1'b0;
		next_nb = nb;
		next_lsb = lsb;
		next_drive = drive;
		case (state)
			ST_IDLE:
			begin
				next_sclk = 1'b0;
				if (commit_req)
				begin
					next_commit = 1'b1;
					next_cnt = 2'h3;
					next_state = ST_COMMIT;
				end
				else if (req)
				begin
					// Whole register each time, command first
					if (lsb_first)
						next_tx = {rev8(cmd), rev64(req_wdata)};
					else
						next_tx = {cmd, req_wdata << (7'd64 - {nbytes, 3'b000})};
					next_bits_left = 7'(8 + nbytes * 8);
					next_rd = req_read;
					next_rx = 64'h0;
					next_cs_n = 1'b0;
					next_nb = nbytes;
					next_lsb = lsb_first;
					next_drive = 1'b1;
					next_cnt = 2'(serial_config_pkg::HOST_CLK_DIV - 1);
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT:
			begin
				next_cnt = cnt - 2'h1;
				if (abort_req && (!sclk || cnt == 2'h0))
				begin
					// Cut on a low clock or at the end of a high phase, so a high phase keeps its full length
					next_sclk = 1'b0;
					next_cs_n = 1'b1;
					next_drive = 1'b0;
					next_state = ST_IDLE;
				end
				else if (cnt == 2'h0)
				begin
					next_cnt = 2'(serial_config_pkg::HOST_CLK_DIV - 1);
					next_sclk = !sclk;
					if (!sclk)
						next_bits_left = bits_left - 7'h1;
					else
					begin
						// Bit of the last rising edge has now passed both sync stages
						if (rd && bits_left < 7'(nb * 8))
							next_rx[rx_pos] = din;
						// Line handed over only after the port took the last command bit
						if (rd && bits_left <= 7'(nb * 8))
							next_drive = 1'b0;
						next_tx = {tx[70:0], 1'b0};
						if (bits_left == 7'h0)
						begin
							next_cs_n = 1'b1;
							next_drive = 1'b0;
							next_done = 1'b1;
							next_state = ST_IDLE;
						end
					end
				end
			end
			ST_COMMIT:
			begin
				// Held several cycles, longer than a device clock period
				next_cnt = cnt - 2'h1;
				if (cnt == 2'h0)
				begin
					next_commit = 1'b0;
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			tx <= 72'h0;
			bits_left <= 7'h0;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			rd <= 1'b0;
			rx <= 64'h0;
			cnt <= 2'h0;
			commit <= 1'b0;
			abort <= 1'b0;
			done <= 1'b0;
			s1 <= 2'h0;
			s2 <= 2'h0;
			nb <= 4'h0;
			lsb <= 1'b0;
			drive <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tx <= next_tx;
			bits_left <= next_bits_left;
			sclk <= next_sclk;
			cs_n <= next_cs_n;
			rd <= next_rd;
			rx <= next_rx;
			cnt <= next_cnt;
			commit <= next_commit;
			abort <= next_abort;
			done <= next_done;
			s1 <= {link.sdo_line, link.sdio};
			s2 <= s1;
			nb <= next_nb;
			lsb <= next_lsb;
			drive <= next_drive;
		end
	end

	// Bit order follows lsb_first, which must match the port's control bit
	assign link.sclk = sclk;
	assign link.cs_n = cs_n;
	assign link.port_abort = abort;
	assign link.commit = commit;
	assign link.profile_sel = profile;
	assign link.sdio_host_out = tx[71];
	assign link.sdio_host_oe = drive;
	assign busy = (state != ST_IDLE);
	assign rdata = rx;
endmodule : serial_config_host

// >>> tb/serial_config_checker.sv
// Protocol checker watching the serial configuration link
`timescale 1ns/10ps
module serial_config_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic port_abort,
	input wire logic commit,
	input wire logic sdio_host_out,
	input wire logic sdio_host_oe,
	input wire logic sdio_dev_out,
	input wire logic sdio_dev_oe,
	input wire logic serial_data_out_oe
);
	logic [7:0] edges;
	logic [7:0] next_edges;
	logic cut;
	logic next_cut;
	logic sclk_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Aborted frames are exempt from the whole-byte count
	always_comb
	begin
		next_edges = edges;
		next_cut = cut | port_abort;
		if (cs_n)
		begin
			next_edges = 8'h00;
			next_cut = port_abort;
		end
		else if (sclk && !sclk_q)
			next_edges = edges + 8'h01;
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			edges <= 8'h00;
			cut <= 1'b0;
			sclk_q <= 1'b0;
		end
		else
		begin
			edges <= next_edges;
			cut <= next_cut;
			sclk_q <= sclk;
		end
	end
	a_frame_length: assert property ($rose(cs_n) && !cut && !port_abort |-> edges[2:0] == 3'h0 && edges >= 8'h10)
		else $error("frame is not command plus whole bytes");
	a_idle_hiz: assert property (cs_n [*4] |-> !sdio_dev_oe && !serial_data_out_oe)
		else $error("device drives data while deselected");
	a_single_driver: assert property (!(sdio_dev_oe && sdio_host_oe))
		else $error("both ends drive the data line");
	a_rd_bit_stable: assert property (sdio_dev_oe && $rose(sclk) |-> $stable(sdio_dev_out))
		else $error("read bit changed at rising clock");
	a_wr_bit_stable: assert property (sdio_host_oe && $rose(sclk) |-> $stable(sdio_host_out))
		else $error("write bit changed at rising clock");
	a_commit_held: assert property ($rose(commit) |-> commit [*2])
		else $error("commit strobe too short");
	a_clock_rest: assert property (cs_n [*2] |-> !sclk)
		else $error("serial clock runs outside a frame");
	a_sclk_half: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("serial clock high phase wrong");
	cover property ($rose(sdio_dev_oe));
	cover property ($rose(serial_data_out_oe));
	cover property (port_abort && !cs_n);
endmodule : serial_config_checker

// >>> tb/tb.sv
// Bench joining host and device ends of the serial link
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req = 1'b0;
	logic req_read = 1'b0;
	logic [4:0] req_addr = 5'h00;
	logic [63:0] req_wdata = 64'h0;
	logic three_wire = 1'b0;
	logic lsb_first = 1'b0;
	logic [63:0] wire_bits = 64'h0;
	logic commit_req = 1'b0;
	logic abort_req = 1'b0;
	logic [2:0] profile = 3'h0;
	logic busy;
	logic done;
	logic [63:0] rdata;
	logic [63:0] active_data [32];
	logic commit_done;
	logic sdo_seen = 1'b0;
	int rises = 0;
	int target = 0;
	int error_cnt = 0;
	int n_checks = 0;
	serial_config_if link_if ();
	serial_config_port serial_config_port_inst (.clk(clk), .reset(reset), .link(link_if),
		.active_data(active_data), .commit_done(commit_done));
	serial_config_host serial_config_host_inst (.clk(clk), .reset(reset), .link(link_if), .req(req),
		.req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata), .lsb_first(lsb_first),
		.three_wire(three_wire), .commit_req(commit_req), .abort_req(abort_req), .profile(profile),
		.busy(busy), .done(done), .rdata(rdata));
	serial_config_checker serial_config_checker_inst (.clk(clk), .reset(reset), .sclk(link_if.sclk),
		.cs_n(link_if.cs_n), .port_abort(link_if.port_abort), .commit(link_if.commit),
		.sdio_host_out(link_if.sdio_host_out), .sdio_host_oe(link_if.sdio_host_oe),
		.sdio_dev_out(link_if.sdio_dev_out), .sdio_dev_oe(link_if.sdio_dev_oe),
		.serial_data_out_oe(link_if.serial_data_out_oe));
	always #25 clk = ~clk;
	always @(posedge link_if.sclk) rises++;
	always @(posedge link_if.sclk) wire_bits <= {wire_bits[62:0], link_if.sdio};
	always @(posedge clk) if (link_if.serial_data_out_oe === 1'b1) sdo_seen <= 1'b1;
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// 0 done, 1 commit_done, 2 idle, 3 edge count
	task automatic wait_hi(input int sel);
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(negedge clk);
			if ((sel == 0 && done === 1'b1) || (sel == 1 && commit_done === 1'b1) ||
				(sel == 2 && busy === 1'b0) || (sel == 3 && rises >= target))
				break;
		end
		if (i == 3000)
		begin
			$display("[ERR] wait %0d expected 1 seen 0", sel);
			error_cnt++;
			stop_test();
		end
	endtask : wait_hi
	task automatic start(input bit rd, input logic [4:0] a, input logic [63:0] d);
		@(negedge clk);
		req = 1'b1;
		req_read = rd;
		req_addr = a;
		req_wdata = d;
		@(negedge clk);
		req = 1'b0;
	endtask : start
	task automatic xfer(input bit rd, input logic [4:0] a, input logic [63:0] d);
		start(rd, a, d);
		wait_hi(0);
	endtask : xfer
	task automatic do_commit();
		@(negedge clk);
		commit_req = 1'b1;
		@(negedge clk);
		commit_req = 1'b0;
		wait_hi(1);
	endtask : do_commit
	function automatic logic [63:0] fit(input logic [4:0] a, input logic [63:0] d);
		if (a == 5'h05 || a == 5'h06)
			return d & 64'hFFFF;
		if (a == 5'h0B || a == 5'h0C || (a >= 5'h0E && a <= 5'h15))
			return d;
		return d & 64'hFFFF_FFFF;
	endfunction : fit
	task automatic test_commit();
		xfer(0, 5'h01, 64'h0123456789ABCDEF);
		check("buffered", active_data[1], 64'h0);
		do_commit();
		check("active", active_data[1], 64'h89ABCDEF);
		xfer(0, 5'h02, 64'h5A5A5A5A);
		xfer(1, 5'h02, 64'h0);
		check("stale", rdata, 64'h0);
		xfer(1, 5'h01, 64'h0);
		check("readback", rdata, 64'h89ABCDEF);
		$display("test_commit done");
	endtask : test_commit
	task automatic test_widths();
		logic [4:0] a [3] = '{5'h05, 5'h0B, 5'h16};
		foreach (a[i]) xfer(0, a[i], 64'hFEDCBA9876543210 ^ {59'h0, a[i]});
		do_commit();
		foreach (a[i])
		begin
			xfer(1, a[i], 64'h0);
			check("width", rdata, fit(a[i], 64'hFEDCBA9876543210 ^ {59'h0, a[i]}));
		end
		$display("test_widths done");
	endtask : test_widths
	task automatic test_profile();
		xfer(0, 5'h13, 64'h0F1E2D3C4B5A6978);
		@(negedge clk);
		profile = 3'h5;
		wait_hi(1);
		check("profile_commit", active_data[19], 64'h0F1E2D3C4B5A6978);
		xfer(1, 5'h13, 64'h0);
		check("profile_read", rdata, 64'h0F1E2D3C4B5A6978);
		$display("test_profile done");
	endtask : test_profile
	task automatic test_abort();
		target = rises + 28;
		start(0, 5'h0C, 64'hC3A5_9617_2468_ACE0);
		wait_hi(3);
		abort_req = 1'b1;
		repeat (8) @(negedge clk);
		abort_req = 1'b0;
		wait_hi(2);
		xfer(0, 5'h01, 64'h11223344);
		do_commit();
		check("after_abort", active_data[1], 64'h11223344);
		check("kept_bytes", active_data[12], 64'hC3A5_0000_0000_0000);
		$display("test_abort done");
	endtask : test_abort
	task automatic test_three_wire();
		xfer(0, 5'h00, 64'h2);
		do_commit();
		three_wire = 1'b1;
		xfer(1, 5'h01, 64'h0);
		check("three_wire_read", rdata, 64'h11223344);
		check("sdo_used", {63'h0, sdo_seen}, 64'h1);
		xfer(0, 5'h00, 64'h0);
		do_commit();
		three_wire = 1'b0;
		$display("test_three_wire done");
	endtask : test_three_wire
	// Wire order: command 0x06 then 0xB4E1, each least significant bit first
	task automatic test_lsb_first();
		xfer(0, 5'h00, 64'h1);
		do_commit();
		lsb_first = 1'b1;
		xfer(0, 5'h06, 64'hB4E1);
		check("lsb_wr_wire", {40'h0, wire_bits[23:0]}, 64'h60872D);
		do_commit();
		check("lsb_write", active_data[6], 64'hB4E1);
		xfer(1, 5'h06, 64'h0);
		check("lsb_rd_wire", {40'h0, wire_bits[23:0]}, 64'h61872D);
		check("lsb_read", rdata, 64'hB4E1);
		xfer(0, 5'h00, 64'h0);
		do_commit();
		lsb_first = 1'b0;
		xfer(1, 5'h06, 64'h0);
		check("msb_again", rdata, 64'hB4E1);
		$display("test_lsb_first done");
	endtask : test_lsb_first
	initial
	begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		test_commit();
		test_widths();
		test_profile();
		test_abort();
		test_three_wire();
		test_lsb_first();
		stop_test();
	end
endmodule : tb
